// *** hw/itrs_pkg.sv ***
// shared constants and carriers for the id tag read sequencer
package itrs_pkg;

   // sequence numbers as three bcd digits
   localparam logic [11:0] SEQ_ONE_HEAD   = 12'h500;
   localparam logic [11:0] SEQ_TWO_HEAD   = 12'h501;

   // send block word counts and head counts, bcd
   localparam logic [15:0] SEND_WORDS_ONE = 16'h0005;
   localparam logic [15:0] SEND_MIN_TWO   = 16'h0006;
   localparam logic [15:0] SEND_MAX_TWO   = 16'h0010;
   localparam logic [15:0] HEADS_ONE      = 16'h0001;
   localparam logic [15:0] HEADS_TWO      = 16'h0002;

   // send block layout, word offsets
   localparam logic [3:0]  OFF_COUNT      = 4'h0;
   localparam logic [3:0]  OFF_HEADS      = 4'h1;
   localparam logic [3:0]  FIELD_BASE_ONE = 4'h1;
   localparam logic [3:0]  FIELD_BASE_TWO = 4'h2;
   localparam logic [3:0]  LAST_ONE       = 4'h4;
   localparam logic [3:0]  LAST_TWO_1     = 4'h5;
   localparam logic [3:0]  LAST_TWO_2     = 4'h9;
   localparam logic [1:0]  FLD_UNIT       = 2'h0;
   localparam logic [1:0]  FLD_CHAN       = 2'h1;
   localparam logic [1:0]  FLD_ADDR       = 2'h2;
   localparam logic [1:0]  FLD_BYTES      = 2'h3;

   // field limits
   localparam logic [7:0]  UNIT_MAX_NARROW = 8'h07;
   localparam logic [7:0]  UNIT_MAX_WIDE   = 8'h15;
   localparam logic [3:0]  CHAN_ONE        = 4'h1;
   localparam logic [3:0]  CHAN_TWO        = 4'h2;
   localparam logic [7:0]  BYTES_MAX_ONE   = 8'hf4;
   localparam logic [7:0]  BYTES_MAX_TWO   = 8'h76;

   // receive block layout, word offsets
   localparam logic [6:0]  RX_OFF_COUNT    = 7'h00;
   localparam logic [6:0]  RX_DATA_BASE    = 7'h01;
   localparam logic [6:0]  RX_HEAD2_BASE   = 7'h3d;
   localparam logic [7:0]  PAD_BYTE        = 8'h00;

   // one read request toward the id controller
   typedef struct packed {
      logic [7:0]  unit;
      logic [3:0]  chan;
      logic [15:0] addr;
      logic [7:0]  bytes;
   } itrs_req_t;

   // one write into the receive words
   typedef struct packed {
      logic        en;
      logic [6:0]  addr;
      logic [15:0] data;
   } itrs_wr_t;

endpackage : itrs_pkg

// *** hw/itrs_sequencer.sv ***
// Function
// RL1: program supplies real send and receive word areas when both are allocated.
// RL2: unallocated receive gets dummy address; unallocated send gets constant 0000.
// RL3: sequence 500 reads one head; send word count must be 0005.
// RL4: unit number is two bcd digits, 00-07 or 00-15 by controller type.
// RL5: head channel digit 1 or 2; single-channel controller allows only 1.
// RL6: single-head leading address 0000-FFFF, byte count 01-F4.
// RL7: single-head receive word count 0002-0123 written into first receive word.
// RL8: single-head ascii data lands in receive words +1 to +122.
// RL9: ascii data fills from the lowest receive offset upward.
// RL10: sequence 501 serves up to two heads, at most 118 bytes each.
// RL11: two-head send word count 0006-0010, head count 0001-0002.
// RL12: head N fields sit at offsets 4(N-1)+2 to 4(N-1)+5.
// RL13: two-head byte count per head is 01-76.
// RL14: two-head receive count 0002-0120; head N data at 60(N-1)+1 onward.
// RL15: cancel aborts any read in progress and returns to waiting.
// RL16: undefined upper digits of unit, channel and byte words are ignored.
// RL17: all fields range-checked before any request; bad block issues nothing.
`timescale 1ns/1ps
`default_nettype none
module itrs_sequencer
   import itrs_pkg::*;
(
   input  wire logic        clock,      // 50 MHz system clock
   input  wire logic        resetn,     // async reset, active low
   input  wire logic        start,      // pulse: run the sequence in seqNo
   input  wire logic [11:0] seqNo,      // bcd sequence number
   input  wire logic        cancelCmd,  // pulse: abort the running read
   input  wire logic        wideUnits,  // 1: two-channel controller, units to 15
   output logic       [3:0] memRdAddr,  // send block word offset
   input  wire logic [15:0] memRdData,  // send word, one cycle after address
   output itrs_wr_t         memWr,      // receive block write
   output logic             reqValid,   // read request offered
   input  wire logic        reqReady,   // controller link takes request
   output itrs_req_t        req,        // request fields
   input  wire logic        rxValid,    // one ascii byte from the carrier
   input  wire logic  [7:0] rxByte,     // the byte
   output logic             busy,       // sequence running
   output logic             done,       // pulse: sequence ended
   output logic             fault       // last sequence refused its sequence number or its block
);

   typedef enum logic [2:0] {S_IDLE, S_ISSUE, S_TAKE, S_CHECK, S_SEND, S_RECV, S_FINISH}
      itrs_state_t;

   typedef struct packed {
      itrs_state_t       st;
      logic              two;     // two-head sequence
      logic              heads2;  // two heads requested
      logic              head;    // current head
      logic              bad;     // send word count or head count out of range
      logic [3:0]        rdAddr;
      logic [1:0][7:0]   unit;
      logic [1:0][3:0]   chan;
      logic [1:0][15:0]  addr;
      logic [1:0][7:0]   nb;
      logic [7:0]        rem;
      logic [7:0]        hold;
      logic              hiPh;
      logic [6:0]        ptr;
      itrs_wr_t          wr;
      logic              done;
      logic              fault;
   } itrs_regs_t;

   itrs_regs_t s_r;
   itrs_regs_t s_nxt;

   // true when every nibble is a decimal digit
   function automatic logic bcdOk(input logic [15:0] v);
      bcdOk = (v[3:0] <= 4'h9) && (v[7:4] <= 4'h9) && (v[11:8] <= 4'h9) && (v[15:12] <= 4'h9);
   endfunction : bcdOk

   // binary receive count to four bcd digits
   function automatic logic [15:0] toBcd(input logic [6:0] v);
      logic [3:0] h;
      logic [3:0] t;
      logic [3:0] o;
      h = 4'(v / 7'd100);
      t = 4'((v % 7'd100) / 7'd10);
      o = 4'(v % 7'd10);
      toBcd = {4'h0, h, t, o};
   endfunction : toBcd

   // range check of one head's fields
   function automatic logic headOk(input logic [7:0] u, input logic [3:0] c,
                                   input logic [7:0] b, input logic two, input logic wide);
      logic uOk;
      logic cOk;
      logic bOk;
      uOk = bcdOk({8'h00, u}) && (u <= (wide ? UNIT_MAX_WIDE : UNIT_MAX_NARROW)); // [RL4]
      cOk = (c == CHAN_ONE) || (wide && (c == CHAN_TWO));                          // [RL5]
      bOk = (b != 8'h00) && (b <= (two ? BYTES_MAX_TWO : BYTES_MAX_ONE));         // [RL6] [RL13]
      headOk = uOk && cOk && bOk;
   endfunction : headOk

   // next-state logic
   always_comb begin
      logic [3:0] rel;
      logic [3:0] last;
      logic       h;
      rel = 4'h0;
      last = 4'h0;
      h = 1'b0;
      s_nxt = s_r;
      s_nxt.wr.en = 1'b0;
      s_nxt.done = 1'b0;
      unique case (s_r.st)
         S_IDLE: begin
            if (start) begin
               s_nxt.two = (seqNo == SEQ_TWO_HEAD);                 // [RL10]
               s_nxt.heads2 = 1'b0;
               s_nxt.head = 1'b0;
               s_nxt.bad = 1'b0;
               s_nxt.rdAddr = OFF_COUNT;
               s_nxt.fault = 1'b0;
               if ((seqNo == SEQ_ONE_HEAD) || (seqNo == SEQ_TWO_HEAD)) begin
                  s_nxt.st = S_ISSUE;
               end else begin
                  s_nxt.fault = 1'b1;
                  s_nxt.done = 1'b1;
               end
            end
         end
         S_ISSUE: begin
            s_nxt.st = S_TAKE;
         end
         S_TAKE: begin
            rel = s_r.rdAddr - (s_r.two ? FIELD_BASE_TWO : FIELD_BASE_ONE);
            h = s_r.two & rel[2];                                     // [RL12]
            if (s_r.rdAddr == OFF_COUNT) begin
               if (s_r.two) begin                                     // [RL11]
                  s_nxt.bad = !bcdOk(memRdData) || (memRdData < SEND_MIN_TWO)
                              || (memRdData > SEND_MAX_TWO);
               end else begin
                  s_nxt.bad = (memRdData != SEND_WORDS_ONE);          // [RL3]
               end
            end else if (s_r.two && (s_r.rdAddr == OFF_HEADS)) begin
               s_nxt.heads2 = (memRdData == HEADS_TWO);               // [RL11]
               if ((memRdData != HEADS_ONE) && (memRdData != HEADS_TWO)) begin
                  s_nxt.bad = 1'b1;
               end
            end else begin
               // only the defined low digits are kept
               unique case (rel[1:0])
                  FLD_UNIT:  s_nxt.unit[h] = memRdData[7:0];         // [RL16]
                  FLD_CHAN:  s_nxt.chan[h] = memRdData[3:0];         // [RL16]
                  FLD_ADDR:  s_nxt.addr[h] = memRdData;              // [RL6]
                  FLD_BYTES: s_nxt.nb[h] = memRdData[7:0];           // [RL16]
               endcase
            end
            // stop after the last word of the last head
            if (!s_r.two) begin
               last = LAST_ONE;
            end else if (s_r.rdAddr == OFF_HEADS) begin
               last = (memRdData == HEADS_TWO) ? LAST_TWO_2 : LAST_TWO_1;
            end else begin
               last = s_r.heads2 ? LAST_TWO_2 : LAST_TWO_1;
            end
            if (s_r.rdAddr >= last && s_r.rdAddr != OFF_COUNT) begin
               s_nxt.st = S_CHECK;
            end else begin
               s_nxt.rdAddr = s_r.rdAddr + 4'h1;
               s_nxt.st = S_ISSUE;
            end
         end
         S_CHECK: begin
            // nothing goes out unless the whole block is in range
            if (s_r.bad
                || !headOk(s_r.unit[0], s_r.chan[0], s_r.nb[0], s_r.two, wideUnits)
                || (s_r.heads2
                    && !headOk(s_r.unit[1], s_r.chan[1], s_r.nb[1], s_r.two, wideUnits)))
            begin                                                     // [RL17]
               s_nxt.fault = 1'b1;
               s_nxt.done = 1'b1;
               s_nxt.st = S_IDLE;
            end else begin
               s_nxt.head = 1'b0;
               s_nxt.ptr = RX_DATA_BASE;                              // [RL8] [RL9]
               s_nxt.st = S_SEND;
            end
         end
         S_SEND: begin
            if (reqReady) begin
               s_nxt.rem = s_r.nb[s_r.head];
               s_nxt.hiPh = 1'b1;
               s_nxt.st = S_RECV;
            end
         end
         S_RECV: begin
            if (rxValid) begin
               s_nxt.rem = s_r.rem - 8'h01;
               if (s_r.hiPh && (s_r.rem != 8'h01)) begin
                  s_nxt.hold = rxByte;
                  s_nxt.hiPh = 1'b0;
               end else begin
                  // two ascii bytes per word, first byte high, upward fill
                  s_nxt.wr.en = 1'b1;                                 // [RL9]
                  s_nxt.wr.addr = s_r.ptr;
                  s_nxt.wr.data = s_r.hiPh ? {rxByte, PAD_BYTE} : {s_r.hold, rxByte};
                  s_nxt.ptr = s_r.ptr + 7'h01;
                  s_nxt.hiPh = 1'b1;
               end
               if (s_r.rem == 8'h01) begin
                  if (s_r.heads2 && !s_r.head) begin
                     s_nxt.head = 1'b1;
                     s_nxt.ptr = RX_HEAD2_BASE;                       // [RL14]
                     s_nxt.st = S_SEND;
                  end else begin
                     s_nxt.st = S_FINISH;
                  end
               end
            end
         end
         S_FINISH: begin
            // count word counts itself plus every word up to the last data word written
            s_nxt.wr.en = 1'b1;                                       // [RL7] [RL14]
            s_nxt.wr.addr = RX_OFF_COUNT;
            s_nxt.wr.data = toBcd(s_r.ptr);
            s_nxt.done = 1'b1;
            s_nxt.st = S_IDLE;
         end
      endcase
      // cancel drops whatever is running without a done pulse
      if (cancelCmd && (s_r.st != S_IDLE)) begin                      // [RL15]
         s_nxt.st = S_IDLE;
         s_nxt.wr.en = 1'b0;
         s_nxt.done = 1'b0;
      end
   end

   // state register
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   // outputs
   assign memRdAddr = s_r.rdAddr;
   assign memWr     = s_r.wr;
   assign reqValid  = (s_r.st == S_SEND);
   assign req       = '{unit: s_r.unit[s_r.head], chan: s_r.chan[s_r.head],
                        addr: s_r.addr[s_r.head], bytes: s_r.nb[s_r.head]};
   assign busy      = (s_r.st != S_IDLE);
   assign done      = s_r.done;
   assign fault     = s_r.fault;

endmodule : itrs_sequencer
`default_nettype wire

// *** test/itrs_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
module itrs_properties
   import itrs_pkg::*;
(
   input wire logic        clock,     // clock
   input wire logic        resetn,    // reset
   input wire logic        start,     // go
   input wire logic [11:0] seqNo,     // sequence
   input wire logic        cancelCmd, // abort
   input wire logic        wideUnits, // type
   input wire logic  [3:0] memRdAddr, // offset
   input wire itrs_wr_t    memWr,     // write
   input wire logic        reqValid,  // offer
   input wire logic        reqReady,  // take
   input wire itrs_req_t   req,       // fields
   input wire logic        busy,      // run
   input wire logic        done,      // end
   input wire logic        fault      // refused
);
   logic twoMode;
   logic goodSeq;
   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);
   // kind of the running sequence
   assign goodSeq = seqNo == SEQ_ONE_HEAD || seqNo == SEQ_TWO_HEAD;
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) twoMode <= 1'b0;
      else if (start && !busy) twoMode <= seqNo == SEQ_TWO_HEAD;
   end
   // fetch, request and receive relations
   a_fetch_start: assert property (start && !busy && goodSeq |=> busy && !memRdAddr)
      else $error("fetch start");
   a_seq_refused: assert property (start && !busy && !goodSeq |=> done && fault)
      else $error("bad sequence kept");
   a_fetch_step: assert property (busy && $past(busy) && $changed(memRdAddr)
      |-> memRdAddr == $past(memRdAddr) + 4'h1) else $error("offset order");
   a_req_hold: assert property (reqValid && !reqReady && !cancelCmd |=> reqValid && $stable(req))
      else $error("request moved");
   a_req_once: assert property (reqValid && reqReady |=> !reqValid)
      else $error("request repeated");
   a_req_range: assert property (reqValid |-> req.bytes != 8'h00
      && req.bytes <= BYTES_MAX_ONE && req.unit <= UNIT_MAX_WIDE
      && (req.chan == CHAN_ONE || req.chan == CHAN_TWO)) else $error("field range");
   a_two_bytes: assert property (reqValid && twoMode |-> req.bytes <= BYTES_MAX_TWO)
      else $error("two head bytes");
   a_narrow_unit: assert property (reqValid && !wideUnits
      |-> req.unit <= UNIT_MAX_NARROW && req.chan == CHAN_ONE) else $error("narrow unit");
   a_cancel_idle: assert property (cancelCmd && busy |=> !busy && !done)
      else $error("cancel");
   a_count_last: assert property (done && !fault |-> memWr.en && memWr.addr == RX_OFF_COUNT)
      else $error("count word");
   c_two_head: cover property (done && !fault && twoMode);
   c_refused: cover property (done && fault);
   c_cancel: cover property (cancelCmd && busy);
endmodule : itrs_properties
bind itrs_sequencer itrs_properties chk (.clock, .resetn, .start, .seqNo, .cancelCmd,
   .wideUnits, .memRdAddr, .memWr, .reqValid, .reqReady, .req, .busy, .done, .fault);
`default_nettype wire

// *** test/itrs_tag_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module itrs_tag_model
   import itrs_pkg::*;
(
   input  wire logic      clock,    // clock
   input  wire logic      resetn,   // reset
   input  wire logic      slow,     // stall at random
   input  wire logic      reqValid, // offer
   input  wire itrs_req_t req,      // fields
   output logic           reqReady, // take
   output logic           rxValid,  // byte strobe
   output logic     [7:0] rxByte    // byte
);
   itrs_req_t held;
   int        sent;
   // takes a request, then returns exactly its byte count, lowest address first
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         reqReady <= 1'b0;
         rxValid <= 1'b0;
         rxByte <= 8'h00;
         sent <= 0;
         held <= '0;
      end else begin
         reqReady <= sent >= held.bytes && (!slow || 1'($urandom));
         if (reqValid && reqReady) begin
            held <= req;
            sent <= 0;
            rxValid <= 1'b0;
         end else if (sent < held.bytes && (!slow || 1'($urandom))) begin
            rxValid <= 1'b1;
            rxByte <= (held.addr[7:0] ^ held.unit) + 8'(sent);
            sent <= sent + 1;
         end else begin
            rxValid <= 1'b0;
            rxByte <= ~rxByte; // idle line inverts the held byte every cycle except the one that takes a request
         end
      end
   end
endmodule : itrs_tag_model
`default_nettype wire

// *** test/tb_itrs_sequencer.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin mismatches++; \
   $display("wrong value %s expected %h seen %h", nm, e, g); end end
module tb_itrs_sequencer
   import itrs_pkg::*;
;
   logic clock, resetn, start, cancelCmd, wideUnits, reqValid, reqReady, rxValid;
   logic busy, done, fault, slow;
   logic [11:0] seqNo;
   logic  [3:0] memRdAddr;
   logic [15:0] memRdData;
   logic  [7:0] rxByte;
   itrs_wr_t    memWr;
   itrs_req_t   req;
   logic [15:0] sendMem [16];  // both sequences get real send and receive areas
   logic [15:0] rxMem [123];
   logic [15:0] expMem [123];
   logic [15:0] blk [10];
   int          mismatches = 0;
   int          total_checks = 0;
   logic [31:0] badCases [12] = '{32'h00040000, 32'h000400f5, 32'h00000004, 32'h00010008,
      32'h00020002, 32'h01010016, 32'h0101001a, 32'h10000011, 32'h10010003, 32'h10010000,
      32'h11050077, 32'h11030003};
   itrs_sequencer DUT (.clock, .resetn, .start, .seqNo, .cancelCmd, .wideUnits, .memRdAddr,
      .memRdData, .memWr, .reqValid, .reqReady, .req, .rxValid, .rxByte, .busy, .done, .fault);
   itrs_tag_model tag (.clock, .resetn, .slow, .reqValid, .req, .reqReady, .rxValid, .rxByte);
   // clock and the word memory on both sides
   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   always @(posedge clock) begin
      memRdData <= sendMem[memRdAddr];
      if (memWr.en) rxMem[memWr.addr] <= memWr.data;
   end
   function automatic logic [15:0] bcd4(input int v);
      return {4'(v / 1000), 4'(v / 100 % 10), 4'(v / 10 % 10), 4'(v % 10)};
   endfunction : bcd4
   task automatic complete_run;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : complete_run
   // legal block with random undefined upper digits
   task automatic rand_blk(input logic two, input logic wide);
      int fb;
      fb = two ? 2 : 1;
      blk[0] = two ? bcd4(6 + $urandom % 5) : SEND_WORDS_ONE;
      blk[1] = bcd4(1 + $urandom % 2);
      for (int h = 0; h < 2; h++) begin
         blk[fb+4*h] = {8'($urandom), 8'h00} | (bcd4(wide ? $urandom % 16 : $urandom % 8) & 16'hff);
         blk[fb+4*h+1] = {12'($urandom), wide ? 4'(1 + $urandom % 2) : CHAN_ONE};
         blk[fb+4*h+2] = 16'($urandom);
         blk[fb+4*h+3] = {8'($urandom), 8'(1 + $urandom % (two ? 118 : 244))};
      end
   endtask : rand_blk
   task automatic run(input logic [11:0] sq, input logic bad, input logic abort);
      int fb, last, n;
      logic [7:0] u;
      fb = (sq == SEQ_ONE_HEAD) ? 1 : 2;
      for (int i = 0; i < 123; i++) begin
         rxMem[i] = 16'hffff;
         expMem[i] = 16'hffff;
      end
      for (int i = 0; i < 10; i++) sendMem[i] = blk[i];
      slow = 1'($urandom);
      @(posedge clock);
      #1 seqNo = sq;
      start = 1'b1;
      @(posedge clock);
      #1 start = 1'b0;
      if (abort) begin
         for (int k = 0; k < 900 && memWr.en !== 1'b1; k++) @(negedge clock);
         @(posedge clock);
         #1;
         `CHK("busy", 1'b1, busy)
         cancelCmd = 1'b1;
         @(posedge clock);
         #1 cancelCmd = 1'b0;
         `CHK("busy", 1'b0, busy)
         return;
      end
      for (int k = 0; k < 3000 && done !== 1'b1; k++) @(negedge clock);
      `CHK("done", 1'b1, done)
      `CHK("fault", bad, fault)
      last = 1;
      for (int h = 0; !bad && h < ((fb == 1) ? 1 : blk[1][1:0]); h++) begin
         n = blk[fb+4*h+3][7:0];
         u = blk[fb+4*h][7:0];
         for (int i = 0; i < n; i++)
            if (i % 2 == 0) expMem[1+60*h+i/2] = {(blk[fb+4*h+2][7:0] ^ u) + 8'(i), PAD_BYTE};
            else expMem[1+60*h+i/2][7:0] = (blk[fb+4*h+2][7:0] ^ u) + 8'(i);
         last = 1 + 60 * h + (n + 1) / 2;
      end
      if (!bad) expMem[0] = bcd4(last);
      @(posedge clock);
      #1;
      for (int i = 0; i < 123; i++) `CHK("receive word", expMem[i], rxMem[i])
   endtask : run
   // watchdog
   initial begin
      #1500000;
      mismatches++;
      complete_run;
   end
   // boundaries, refusals, cancel, then random reads
   initial begin
      void'($urandom(57779));
      {resetn, start, cancelCmd, wideUnits, slow} = 5'h00;
      seqNo = 12'h000;
      repeat (3) @(posedge clock);
      #1 resetn = 1'b1;
      wideUnits = 1'b1; // directed legal blocks may use channel 2 and units to 15
      rand_blk(1'b0, 1'b1);
      blk[4] = 16'hfff4;
      run(SEQ_ONE_HEAD, 1'b0, 1'b0);
      rand_blk(1'b1, 1'b1);
      blk[1] = HEADS_TWO;
      blk[9] = 16'h0076;
      run(SEQ_TWO_HEAD, 1'b0, 1'b0);
      for (int t = 0; t < 12; t++) begin
         wideUnits = badCases[t][24];
         rand_blk(badCases[t][28], wideUnits);
         blk[badCases[t][23:16]] = badCases[t][15:0];
         run(badCases[t][28] ? SEQ_TWO_HEAD : SEQ_ONE_HEAD, 1'b1, 1'b0);
      end
      run(12'h502, 1'b1, 1'b0);
      rand_blk(1'b1, wideUnits);
      blk[1] = HEADS_TWO;
      blk[5] = 16'h0076; // long first head so the cancel lands mid-receive
      run(SEQ_TWO_HEAD, 1'b0, 1'b1);
      for (int t = 0; t < 16; t++) begin
         wideUnits = 1'($urandom);
         rand_blk(1'(t % 2), wideUnits);
         run((t % 2) ? SEQ_TWO_HEAD : SEQ_ONE_HEAD, 1'b0, 1'b0);
      end
      complete_run;
   end
endmodule : tb_itrs_sequencer
`default_nettype wire
